// [efs_consts.svh]
// Purpose: constants for the encoder feedback setup block
// Assumes: one clock, synchronous active-high reset
// Notes: offsets index 32-bit registers on a plain port
`ifndef EFS_CONSTS_SVH
`define EFS_CONSTS_SVH
`define EFS_ADDR_PPR        4'h0
`define EFS_ADDR_DIR        4'h1
`define EFS_ADDR_DIV        4'h2
`define EFS_ADDR_MTEETH     4'h3
`define EFS_ADDR_ETEETH     4'h4
`define EFS_ADDR_RES        4'h5
`define EFS_ADDR_OFFSET     4'h6
`define EFS_ADDR_ENCTYPE    4'h7
`define EFS_ADDR_CARD       4'h8
`define EFS_ADDR_SPEED      4'h9
`define EFS_ADDR_POS        4'ha
`define EFS_ADDR_STATUS     4'hb
`define EFS_ADDR_PULSES     4'hc
`define EFS_PPR_512         16'h0200
`define EFS_PPR_1024        16'h0400
`define EFS_PPR_2048        16'h0800
`define EFS_RST_PPR         16'h0400
`define EFS_RST_DIV         8'h01
`define EFS_RST_TEETH       16'h0001
`define EFS_RST_RES         2'h2
`define EFS_RST_OFFSET      16'h003c
`define EFS_RES_16384       2'h0
`define EFS_RES_32768       2'h1
`define EFS_RES_8192        2'h2
`define EFS_CNT_16384       16'h4000
`define EFS_CNT_32768       16'h8000
`define EFS_CNT_8192        16'h2000
`define EFS_DIV_M_MAX       8'h20
`define EFS_RPM_FACTOR      32'h0000003c
`define EFS_CLK_HZ          200000000
`define EFS_GATE_S_NUM      1
`define EFS_GATE_S_DEN      10
`define EFS_GATE_CYCLES     (`EFS_CLK_HZ * `EFS_GATE_S_NUM / `EFS_GATE_S_DEN)
`endif

// [efs_pkg.sv]
// Purpose: types for the encoder feedback setup block
// Assumes: constants header provides numbers
// Notes: types only
package efs_pkg;
    typedef enum logic [1:0] {
        EFS_CARD_AB_OC,
        EFS_CARD_ABZ_LD,
        EFS_CARD_SERIAL,
        EFS_CARD_NONE
    } efs_card_type;
    typedef struct packed {
        logic ch_a;
        logic ch_b;
        logic ch_z;
    } efs_quad_type;
    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } efs_bus_type;
endpackage

// [efs_top.sv]
// Purpose: encoder feedback setup, decode, pulse monitor and speed
// Assumes: encoder pins synchronous to i_clock; ratio settings static
// Notes: speed sampled over a fixed gate window
//        illegal setting writes are dropped and the old value stays
//        speed scale assumes ten gate windows per second
//        a step is a change on exactly one encoder channel
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "efs_consts.svh"
module efs_top import efs_pkg::*; #(
    parameter int GATE_CYCLES = `EFS_GATE_CYCLES
) (
    input  wire logic         i_clock,
    input  wire logic         i_reset,
    input  wire efs_bus_type  i_bus,
    output logic [31:0]       o_rdata,
    input  wire efs_quad_type i_enc,
    input  wire logic         i_fwd_cmd,
    input  wire logic         i_open_loop_im,
    input  wire logic [15:0]  i_internal_speed,
    input  wire logic         i_tune_valid,
    input  wire logic [15:0]  i_tune_offset,
    output logic              o_pulse_mon,
    output logic              o_reverse,
    output logic              o_dir_error,
    output logic [15:0]       o_speed_monitor_value
);
    // Settings held for software
    logic [15:0] pulses_per_rev_setting_r;
    logic        feedback_direction_select_r;
    logic [7:0]  pulse_monitor_divider_r;
    logic [15:0] motor_side_gear_teeth_r;
    logic [15:0] encoder_side_gear_teeth_r;
    logic [1:0]  serial_resolution_select_r;
    logic [15:0] magnet_position_offset_r;
    logic        encoder_type_select_r;
    efs_card_type card_r;

    // Quadrature decode and position
    logic [1:0]  ab_prev_r;
    logic [31:0] position_r;
    logic        step;
    logic        step_up;

    // Pulse monitor divider
    logic [5:0]  div_acc_r;
    logic        div_n;
    logic [5:0]  div_m;

    // Gate window and serial divider
    logic [31:0] gate_cnt_r;
    logic [31:0] pulse_cnt_r;
    logic [31:0] pulse_lat_r;
    logic [15:0] meas_speed_r;
    logic        calc_busy_r;
    logic [63:0] calc_num_r;
    logic [63:0] calc_den_r;
    logic [15:0] calc_q_r;
    logic [4:0]  calc_bit_r;
    logic        calc_sat_r;

    // Combinational helpers
    logic [15:0] res_counts;
    logic        wr_ok_ppr;
    logic [5:0]  div_acc_nxt;

    // Field split of divider code: upper digit n, lower digits m
    // decode n and m
    always_comb begin
        div_n = (pulse_monitor_divider_r >= 8'd100);
        div_m = div_n ? 6'(pulse_monitor_divider_r - 8'd100) : 6'(pulse_monitor_divider_r);
    end

    // Legal pulse count per encoder type
    // Checked on the incoming word, so a refused count never lands
    // Non-serial cards take any count the software writes
    // legal ppr values
    always_comb begin
        if (card_r != EFS_CARD_SERIAL) begin
            wr_ok_ppr = 1'b1;
        end else if (!encoder_type_select_r) begin
            wr_ok_ppr = (i_bus.wdata[15:0] == `EFS_PPR_1024);
        end else begin
            wr_ok_ppr = (i_bus.wdata[15:0] == `EFS_PPR_512) ||
                        (i_bus.wdata[15:0] == `EFS_PPR_1024) ||
                        (i_bus.wdata[15:0] == `EFS_PPR_2048);
        end
    end

    // Settings written from the register port
    // Refused values leave the previous setting in place
    // Zero motor teeth would divide by zero in the speed path
    // Writing the second encoder type forces resolution select 2
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            pulses_per_rev_setting_r    <= `EFS_RST_PPR;
            feedback_direction_select_r <= 1'b0;
            pulse_monitor_divider_r     <= `EFS_RST_DIV;
            motor_side_gear_teeth_r     <= `EFS_RST_TEETH;
            encoder_side_gear_teeth_r   <= `EFS_RST_TEETH;
            serial_resolution_select_r  <= `EFS_RST_RES;
            encoder_type_select_r       <= 1'b0;
            card_r                      <= EFS_CARD_AB_OC;
        end else if (i_bus.wr) begin
            if (i_bus.addr == `EFS_ADDR_PPR && wr_ok_ppr) begin
                pulses_per_rev_setting_r <= i_bus.wdata[15:0];
            end else if (i_bus.addr == `EFS_ADDR_DIR) begin
                feedback_direction_select_r <= i_bus.wdata[0];
            end else if (i_bus.addr == `EFS_ADDR_DIV) begin
                if ((i_bus.wdata[7:0] >= 8'd1 && i_bus.wdata[7:0] <= `EFS_DIV_M_MAX) ||
                    (i_bus.wdata[7:0] >= 8'd102 && i_bus.wdata[7:0] <= 8'd132)) begin
                    pulse_monitor_divider_r <= i_bus.wdata[7:0];
                end
            end else if (i_bus.addr == `EFS_ADDR_MTEETH && i_bus.wdata[15:0] != 16'h0000) begin
                motor_side_gear_teeth_r <= i_bus.wdata[15:0];
            end else if (i_bus.addr == `EFS_ADDR_ETEETH && i_bus.wdata[15:0] != 16'h0000) begin
                encoder_side_gear_teeth_r <= i_bus.wdata[15:0];
            end else if (i_bus.addr == `EFS_ADDR_RES) begin
                if (!encoder_type_select_r && i_bus.wdata[1:0] != 2'h3) begin
                    serial_resolution_select_r <= i_bus.wdata[1:0];
                end
            end else if (i_bus.addr == `EFS_ADDR_ENCTYPE) begin
                encoder_type_select_r <= i_bus.wdata[0];
                if (i_bus.wdata[0]) begin
                    serial_resolution_select_r <= `EFS_RES_8192;
                end
            end else if (i_bus.addr == `EFS_ADDR_CARD) begin
                card_r <= efs_card_type'(i_bus.wdata[1:0]);
            end
        end
    end

    // Magnet offset, tuning result wins over a software write
    // Tuning is a one-cycle strobe from the autotune logic
    // Software may still overwrite the offset by hand
    // tuning writes offset
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            magnet_position_offset_r <= `EFS_RST_OFFSET;
        end else if (i_tune_valid) begin
            magnet_position_offset_r <= i_tune_offset;
        end else if (i_bus.wr && i_bus.addr == `EFS_ADDR_OFFSET) begin
            magnet_position_offset_r <= i_bus.wdata[15:0];
        end
    end

    // Quadrature step detect; forward sense set by direction select
    // A double change is a lost edge and is not counted
    // Serial and missing cards never step the count
    // decode up and down
    always_comb begin
        step    = 1'b0;
        step_up = 1'b0;
        if ((card_r == EFS_CARD_AB_OC || card_r == EFS_CARD_ABZ_LD) &&
            ({i_enc.ch_a, i_enc.ch_b} != ab_prev_r) &&
            ({i_enc.ch_a, i_enc.ch_b} != ~ab_prev_r)) begin
            step = 1'b1;
            step_up = (i_enc.ch_a ^ ab_prev_r[0]) ^ feedback_direction_select_r;
        end
    end

    // Position count and direction flags
    // Index pulse on the line-driver card zeroes the count
    // Flags hold their value until the next step
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            ab_prev_r   <= 2'h0;
            position_r  <= 32'h0;
            o_reverse   <= 1'b0;
            o_dir_error <= 1'b0;
        end else begin
            ab_prev_r <= {i_enc.ch_a, i_enc.ch_b};
            if (card_r == EFS_CARD_ABZ_LD && i_enc.ch_z) begin
                position_r <= 32'h0;
            end else if (step) begin
                position_r <= step_up ? position_r + 32'h1 : position_r - 32'h1;
            end
            if (step) begin
                o_reverse   <= !step_up;
                o_dir_error <= i_fwd_cmd && !step_up;
            end
        end
    end

    // Pulse monitor: accumulate (1+n) per step, emit when reaching m
    // Remainder carries over, so the long-run ratio is exact
    // divide only open collector
    always_comb begin
        div_acc_nxt = div_acc_r + (div_n ? 6'd2 : 6'd1);
    end

    // Divided output toggles; other incremental cards pass every step
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            div_acc_r   <= 6'h0;
            o_pulse_mon <= 1'b0;
        end else if (step) begin
            if (card_r != EFS_CARD_AB_OC) begin
                o_pulse_mon <= ~o_pulse_mon;
            end else if (div_acc_nxt >= div_m) begin
                div_acc_r   <= div_acc_nxt - div_m;
                o_pulse_mon <= ~o_pulse_mon;
            end else begin
                div_acc_r <= div_acc_nxt;
            end
        end
    end

    // Gate window counts pulses for the speed calculation
    // The step of the last window cycle is folded into the latch
    // Window length is a parameter so simulation can shorten it
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            gate_cnt_r  <= 32'h0;
            pulse_cnt_r <= 32'h0;
            pulse_lat_r <= 32'h0;
        end else if (gate_cnt_r == 32'(GATE_CYCLES - 1)) begin
            gate_cnt_r  <= 32'h0;
            pulse_lat_r <= pulse_cnt_r + {31'h0, step};
            pulse_cnt_r <= 32'h0;
        end else begin
            gate_cnt_r  <= gate_cnt_r + 32'h1;
            pulse_cnt_r <= pulse_cnt_r + {31'h0, step};
        end
    end

    // Serial bit-wise divide: speed = p*60*enc*gates_per_s/(ppr*motor)
    // One quotient bit per cycle keeps the logic small
    // Quotient above 16 bits saturates at full scale
    // speed formula
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            calc_busy_r  <= 1'b0;
            calc_num_r   <= 64'h0;
            calc_den_r   <= 64'h0;
            calc_q_r     <= 16'h0;
            calc_bit_r   <= 5'h0;
            calc_sat_r   <= 1'b0;
            meas_speed_r <= 16'h0;
        end else if (!calc_busy_r && gate_cnt_r == 32'h0) begin
            calc_busy_r <= 1'b1;
            // Widen before multiplying; a long window would wrap 32 bits
            calc_num_r  <= 64'(pulse_lat_r) * 64'(`EFS_RPM_FACTOR) *
                           64'(`EFS_GATE_S_DEN) * 64'(encoder_side_gear_teeth_r);
            calc_den_r  <= 64'(pulses_per_rev_setting_r) * 64'(motor_side_gear_teeth_r);
            calc_q_r    <= 16'h0;
            calc_sat_r  <= 1'b0;
            calc_bit_r  <= 5'd15;
        end else if (calc_busy_r) begin
            // Quotient too large for 16 bits
            if (calc_bit_r == 5'd15 && calc_num_r >= (calc_den_r << 5'h10)) begin
                calc_sat_r <= 1'b1;
            end
            if (calc_num_r >= (calc_den_r << calc_bit_r)) begin
                calc_num_r <= calc_num_r - (calc_den_r << calc_bit_r);
                calc_q_r   <= calc_q_r | (16'h1 << calc_bit_r);
            end
            if (calc_bit_r == 5'h0) begin
                calc_busy_r  <= 1'b0;
                if (calc_sat_r) begin
                    meas_speed_r <= 16'hffff;
                end else begin
                    meas_speed_r <= calc_q_r |
                        ((calc_num_r >= calc_den_r) ? 16'h1 : 16'h0);
                end
            end else begin
                calc_bit_r <= calc_bit_r - 5'h1;
            end
        end
    end

    // Speed monitor source selection
    // Open loop without an incremental card shows the internal estimate
    // Closed loop always shows the measured speed
    // measured or internal
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_speed_monitor_value <= 16'h0;
        end else if (i_open_loop_im &&
                     (card_r == EFS_CARD_AB_OC || card_r == EFS_CARD_ABZ_LD)) begin
            o_speed_monitor_value <= meas_speed_r;
        end else if (i_open_loop_im) begin
            o_speed_monitor_value <= i_internal_speed;
        end else begin
            o_speed_monitor_value <= meas_speed_r;
        end
    end

    // Resolution counts shown to software
    // Select value 3 is refused on write and never reaches here
    // resolution mapping
    always_comb begin
        if (serial_resolution_select_r == `EFS_RES_16384) begin
            res_counts = `EFS_CNT_16384;
        end else if (serial_resolution_select_r == `EFS_RES_32768) begin
            res_counts = `EFS_CNT_32768;
        end else begin
            res_counts = `EFS_CNT_8192;
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    // Unmapped addresses read as zero
    always_ff @(posedge i_clock) begin
        if (i_reset || !i_bus.rd) begin
            o_rdata <= 32'h0;
        end else if (i_bus.addr == `EFS_ADDR_PPR) begin
            o_rdata <= {16'h0, pulses_per_rev_setting_r};
        end else if (i_bus.addr == `EFS_ADDR_DIR) begin
            o_rdata <= {31'h0, feedback_direction_select_r};
        end else if (i_bus.addr == `EFS_ADDR_DIV) begin
            o_rdata <= {24'h0, pulse_monitor_divider_r};
        end else if (i_bus.addr == `EFS_ADDR_MTEETH) begin
            o_rdata <= {16'h0, motor_side_gear_teeth_r};
        end else if (i_bus.addr == `EFS_ADDR_ETEETH) begin
            o_rdata <= {16'h0, encoder_side_gear_teeth_r};
        end else if (i_bus.addr == `EFS_ADDR_RES) begin
            o_rdata <= {res_counts, 14'h0, serial_resolution_select_r};
        end else if (i_bus.addr == `EFS_ADDR_OFFSET) begin
            o_rdata <= {16'h0, magnet_position_offset_r};
        end else if (i_bus.addr == `EFS_ADDR_ENCTYPE) begin
            o_rdata <= {31'h0, encoder_type_select_r};
        end else if (i_bus.addr == `EFS_ADDR_CARD) begin
            o_rdata <= {30'h0, card_r};
        end else if (i_bus.addr == `EFS_ADDR_SPEED) begin
            o_rdata <= {16'h0, meas_speed_r};
        end else if (i_bus.addr == `EFS_ADDR_POS) begin
            o_rdata <= position_r;
        end else if (i_bus.addr == `EFS_ADDR_STATUS) begin
            o_rdata <= {29'h0, calc_busy_r, o_dir_error, o_reverse};
        end else if (i_bus.addr == `EFS_ADDR_PULSES) begin
            o_rdata <= pulse_lat_r;
        end else begin
            o_rdata <= 32'h0;
        end
    end
endmodule

// [efs_top_monitor.sv]
// Purpose: port checker for the encoder feedback block
// Assumes: bound to efs_top, one clock domain
// Notes: a step is a change on exactly one channel
`timescale 1ns/1ps
module efs_top_monitor import efs_pkg::*; #(
    parameter int GATE_CYCLES = 200
) (
    input  wire logic         i_clock,
    input  wire logic         i_reset,
    input  wire efs_bus_type  i_bus,
    input  wire logic [31:0]  o_rdata,
    input  wire efs_quad_type i_enc,
    input  wire logic         i_fwd_cmd,
    input  wire logic         o_pulse_mon,
    input  wire logic         o_reverse,
    input  wire logic         o_dir_error
);
    logic [1:0] ab_r;
    logic       step;
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_reset);
    // Channel levels one cycle back
    always_ff @(posedge i_clock) begin
        ab_r <= {i_enc.ch_a, i_enc.ch_b};
    end
    assign step = ^(ab_r ^ {i_enc.ch_a, i_enc.ch_b});
    // Read port and decode relations
    a_rdata_idle: assert property (!i_bus.rd |=> o_rdata == 32'h0)
        else $error("read data not zero");
    a_rev_hold: assert property (!step |=> $stable(o_reverse))
        else $error("reverse moved without step");
    a_err_hold: assert property (!step |=> $stable(o_dir_error))
        else $error("direction error moved without step");
    a_pulse_hold: assert property (!step |=> $stable(o_pulse_mon))
        else $error("pulse monitor moved without step");
    a_pulse_cause: assert property ($changed(o_pulse_mon) |-> $past(step))
        else $error("pulse monitor toggle without cause");
    a_err_match: assert property (step && i_fwd_cmd |=> o_dir_error == o_reverse)
        else $error("direction error differs from reverse");
    a_err_clear: assert property (step && !i_fwd_cmd |=> !o_dir_error)
        else $error("direction error without forward command");
    a_err_rev: assert property (o_dir_error |-> o_reverse)
        else $error("direction error while not reverse");
    c_fwd_step: cover property (step && i_fwd_cmd);
    c_err_rise: cover property ($rose(o_dir_error));
    c_read: cover property (i_bus.rd ##1 o_rdata != 32'h0);
endmodule
bind efs_top efs_top_monitor #(.GATE_CYCLES(GATE_CYCLES)) u_mon (
    .i_clock(i_clock), .i_reset(i_reset), .i_bus(i_bus), .o_rdata(o_rdata),
    .i_enc(i_enc), .i_fwd_cmd(i_fwd_cmd), .o_pulse_mon(o_pulse_mon),
    .o_reverse(o_reverse), .o_dir_error(o_dir_error)
);

// [efs_enc_model.sv]
// Purpose: quadrature shaft encoder at the drive pins
// Assumes: one phase step per cycle while i_step is high
// Notes: A leads B while i_up is high
`timescale 1ns/1ps
module efs_enc_model import efs_pkg::*; (
    input  wire logic    i_clock,
    input  wire logic    i_step,
    input  wire logic    i_up,
    input  wire logic    i_zero,
    output efs_quad_type o_enc
);
    logic [1:0] ph_r = 2'h0;
    always @(posedge i_clock) begin
        if (i_step) begin
            ph_r <= i_up ? ph_r + 2'h1 : ph_r - 2'h1;
        end
    end
    // gray order with A rising first
    assign o_enc = '{ph_r[1] ^ ph_r[0], ph_r[1], i_zero && ph_r == 2'h0};
endmodule

// [encoder_feedback_setup_tb_top.sv]
// Purpose: self-checking bench for encoder feedback setup
// Assumes: gate window shortened to 200 cycles
// Notes: read replies checked one cycle after the strobe
`timescale 1ns/1ps
`include "efs_consts.svh"
module encoder_feedback_setup_tb_top import efs_pkg::*;;
    localparam int GATE = 200;
    localparam logic [31:0] RES_T[3] = '{32'h4000_0000, 32'h8000_0001, 32'h2000_0002};
    localparam int DIV_T[4] = '{2, 104, 132, 2};
    localparam int STP_T[4] = '{8, 8, 16, 6};
    localparam int TOG_T[4] = '{4, 4, 1, 6};
    logic         i_clock = 1'b0;
    logic         i_reset = 1'b1;
    efs_bus_type  bus = '0;
    efs_quad_type enc;
    logic [31:0]  o_rdata;
    logic [31:0]  seed = 32'hd449;
    logic [31:0]  exp_q[$];
    logic [15:0]  ispd = 16'h0, toff = 16'h0, spd;
    logic         fwd = 1'b1, olim = 1'b0, tv = 1'b0, step = 1'b0, up = 1'b1, zero = 1'b0;
    logic         pmon, rev, derr, rd_d = 1'b0, pm_d = 1'b0;
    int           error_cnt = 0, samples_checked = 0, tog = 0, cyc = 0;
    always #2.5 i_clock = ~i_clock;
    efs_top #(.GATE_CYCLES(GATE)) i_dut (
        .i_clock(i_clock), .i_reset(i_reset), .i_bus(bus), .o_rdata(o_rdata),
        .i_enc(enc), .i_fwd_cmd(fwd), .i_open_loop_im(olim), .i_internal_speed(ispd),
        .i_tune_valid(tv), .i_tune_offset(toff), .o_pulse_mon(pmon),
        .o_reverse(rev), .o_dir_error(derr), .o_speed_monitor_value(spd)
    );
    efs_enc_model i_enc_model (
        .i_clock(i_clock), .i_step(step), .i_up(up), .i_zero(zero), .o_enc(enc)
    );
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge i_clock);
        bus.wr <= 1'b0;
        @(posedge i_clock);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge i_clock);
        bus.rd <= 1'b0;
        @(posedge i_clock);
    endtask
    task automatic steps(input int n, input logic u);
        up <= u;
        step <= 1'b1;
        repeat (n) @(posedge i_clock);
        step <= 1'b0;
        repeat (3) @(posedge i_clock);
    endtask
    task automatic chk_dir(input logic r, input logic e);
        chk({31'h0, rev}, {31'h0, r});
        chk({31'h0, derr}, {31'h0, e});
    endtask
    // Read replies, toggle count and run limit
    always @(posedge i_clock) begin
        rd_d <= bus.rd;
        pm_d <= pmon;
        if (pmon !== pm_d) tog++;
        if (rd_d) chk(o_rdata, exp_q.pop_front());
        if (++cyc > 20000) begin
            error_cnt++;
            end_sim();
        end
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge i_clock);
        i_reset <= 1'b0;
        @(posedge i_clock);
        rd(`EFS_ADDR_PPR, 32'h400);
        rd(`EFS_ADDR_DIR, 32'h0);
        rd(`EFS_ADDR_DIV, 32'h1);
        rd(`EFS_ADDR_RES, RES_T[2]);
        rd(`EFS_ADDR_OFFSET, 32'h3c);
        rd(4'hd, 32'h0);
        wr(`EFS_ADDR_CARD, 32'h2);
        wr(`EFS_ADDR_PPR, 32'h800);
        rd(`EFS_ADDR_PPR, 32'h400);
        for (int s = 0; s < 4; s++) begin
            wr(`EFS_ADDR_RES, 32'(s));
            rd(`EFS_ADDR_RES, RES_T[s > 2 ? 2 : s]);
        end
        wr(`EFS_ADDR_RES, 32'h0);
        wr(`EFS_ADDR_ENCTYPE, 32'h1);
        rd(`EFS_ADDR_RES, RES_T[2]);
        wr(`EFS_ADDR_RES, 32'h1);
        rd(`EFS_ADDR_RES, RES_T[2]);
        wr(`EFS_ADDR_PPR, 32'h300);
        rd(`EFS_ADDR_PPR, 32'h400);
        for (int i = 0; i < 3; i++) begin
            wr(`EFS_ADDR_PPR, 32'h200 << i);
            rd(`EFS_ADDR_PPR, 32'h200 << i);
        end
        seed = xs(seed);
        toff <= seed[15:0];
        tv <= 1'b1;
        @(posedge i_clock);
        tv <= 1'b0;
        @(posedge i_clock);
        rd(`EFS_ADDR_OFFSET, {16'h0, toff});
        wr(`EFS_ADDR_ENCTYPE, 32'h0);
        wr(`EFS_ADDR_CARD, 32'h0);
        wr(`EFS_ADDR_DIV, 32'd0);
        wr(`EFS_ADDR_DIV, 32'd33);
        rd(`EFS_ADDR_DIV, 32'h1);
        wr(`EFS_ADDR_MTEETH, 32'h0);
        rd(`EFS_ADDR_MTEETH, 32'h1);
        steps(4, 1'b1);
        chk_dir(1'b0, 1'b0);
        steps(3, 1'b0);
        chk_dir(1'b1, 1'b1);
        wr(`EFS_ADDR_DIR, 32'h1);
        toff <= ~toff;
        tv <= 1'b1;
        @(posedge i_clock);
        tv <= 1'b0;
        rd(`EFS_ADDR_OFFSET, {16'h0, toff});
        steps(2, 1'b0);
        chk_dir(1'b0, 1'b0);
        steps(2, 1'b1);
        chk_dir(1'b1, 1'b1);
        fwd <= 1'b0;
        steps(1, 1'b1);
        chk_dir(1'b1, 1'b0);
        fwd <= 1'b1;
        wr(`EFS_ADDR_DIR, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(`EFS_ADDR_CARD, 32'(i == 3));
            wr(`EFS_ADDR_DIV, 32'(DIV_T[i]));
            tog = 0;
            steps(STP_T[i], 1'b1);
            chk(32'(tog), 32'(TOG_T[i]));
        end
        rd(`EFS_ADDR_POS, 32'h26);
        zero <= 1'b1;
        @(posedge i_clock);
        zero <= 1'b0;
        rd(`EFS_ADDR_POS, 32'h0);
        wr(`EFS_ADDR_CARD, 32'h0);
        wr(`EFS_ADDR_PPR, 32'h200);
        wr(`EFS_ADDR_MTEETH, 32'h3);
        wr(`EFS_ADDR_ETEETH, 32'h4);
        fork
            steps(1000, 1'b1);
            begin
                repeat (700) @(posedge i_clock);
                rd(`EFS_ADDR_PULSES, 32'd200);
                rd(`EFS_ADDR_SPEED, 32'd312);
                olim <= 1'b1;
                repeat (3) @(posedge i_clock);
                chk({16'h0, spd}, 32'd312);
            end
        join
        seed = xs(seed);
        ispd <= seed[15:0];
        wr(`EFS_ADDR_CARD, 32'h3);
        repeat (3) @(posedge i_clock);
        chk({16'h0, spd}, {16'h0, ispd});
        end_sim();
    end
endmodule
